/* File: sgw_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  supervisor guard and watchdog block.
  Assumes a 10 MHz core clock and is included by its bare name.
*/
`ifndef SGW_REGS_SVH
`define SGW_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the serial port.
// ----------------------------------------------------------------------------
`define SGW_ADDR_CTRL 8'h00
`define SGW_ADDR_GTIME 8'h01
`define SGW_ADDR_STATUS 8'h02
`define SGW_ADDR_GCOUNT 8'h03
`define SGW_ADDR_SEGUSE 8'h04
`define SGW_ADDR_DIGUSE 8'h05
`define SGW_ADDR_WAKELO 8'h06
`define SGW_ADDR_WAKEHI 8'h07
`define SGW_ADDR_WDOG 8'h09
`define SGW_ADDR_CURR0 8'h0A
`define SGW_ADDR_LAST 8'h0D
`define SGW_READ_FILL 8'hFF

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SGW_CTRL_GEN 0
`define SGW_CTRL_GCLR 1
`define SGW_CTRL_POWER_CUT_OUT 2
`define SGW_CTRL_LP 3
`define SGW_CTRL_DISP 4
`define SGW_STAT_CUT 0
`define SGW_STAT_WDF 1
`define SGW_STAT_HOT 2
`define SGW_STAT_GRUN 3
`define SGW_WD_MULT_HI 7
`define SGW_WD_MULT_LO 3
`define SGW_WD_RES_HI 2
`define SGW_WD_RES_LO 0

// ----------------------------------------------------------------------------
// Reset values and limits.
// ----------------------------------------------------------------------------
`define SGW_CTRL_RESET 8'h08
`define SGW_GTIME_RESET 4'hA
`define SGW_GTIME_MIN 4'h1
`define SGW_WDOG_RESET 8'h00
`define SGW_DEV_ADDR 7'h2A

// ----------------------------------------------------------------------------
// Watchdog resolution codes and their length in sixteenth-second ticks.
// ----------------------------------------------------------------------------
`define SGW_RES_16TH 3'h0
`define SGW_RES_QUART 3'h1
`define SGW_RES_SEC 3'h2
`define SGW_RES_4SEC 3'h3
`define SGW_RES_MIN 3'h4
`define SGW_TICKS_16TH 10'h001
`define SGW_TICKS_QUART 10'h004
`define SGW_TICKS_SEC 10'h010
`define SGW_TICKS_4SEC 10'h040
`define SGW_TICKS_MIN 10'h3C0

// ----------------------------------------------------------------------------
// Timing: base tick of one sixteenth second, derived from the clock period.
// ----------------------------------------------------------------------------
`define SGW_CLK_NS 100
`define SGW_TICK_US 62500
`define SGW_TICK_CYCLES ((`SGW_TICK_US * 1000) / `SGW_CLK_NS)
`define SGW_TICKS_PER_SEC 5'h10

`endif

/* File: sgw_pkg.sv */
/*
  Types shared by the supervisor guard and watchdog modules.
  Assumes nothing of its surroundings.
*/
package sgw_pkg;

  // --------------------------------------------------------------------------
  // Serial link states.
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_WRITE,
    LINK_READ,
    LINK_RACK
  } sgw_link_state_t;

  typedef logic [7:0] sgw_byte_t;

endpackage

/* File: sgw_reg_if.sv */
/*
  Byte channel between the serial link front end and the register file.
  Assumes both ends run on the same core clock.
*/
interface sgw_reg_if;
  import sgw_pkg::*;

  logic wrValid;
  logic wrFirst;
  sgw_byte_t wrData;
  logic rdReq;
  sgw_byte_t rdData;

  modport link (
    output wrValid,
    output wrFirst,
    output wrData,
    output rdReq,
    input rdData
  );

  modport regs (
    input wrValid,
    input wrFirst,
    input wrData,
    input rdReq,
    output rdData
  );
endinterface

/* File: sgw_serial_link.sv */
/*
  Serial slave front end: start and stop detection, bit shifting, address
  match, acknowledge and read data shifting.
  Assumes the clock and data pins are asynchronous and sampled here; the bus
  clock is slow enough for several core cycles per phase.
*/
`include "sgw_regs.svh"

module sgw_serial_link
  import sgw_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `SGW_DEV_ADDR // Arbitrary slave address.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bus pins.
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOe,
  // Byte channel.
  sgw_reg_if.link bus
);
  import sgw_pkg::*;

  logic sclS1, sclS2, sclS3;
  logic sdaS1, sdaS2, sdaS3;
  sgw_link_state_t state_q;
  logic [2:0] bitCnt_q;
  sgw_byte_t shIn_q;
  sgw_byte_t shOut_q;
  logic ackPend_q;
  logic ackDrive_q;
  logic isRead_q;
  logic firstByte_q;
  logic sclRise, sclFall, startSeen, stopSeen;
  sgw_byte_t fullByte;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge detection.
  // ----------------------------------------------------------------------------

  // Two flops per pin, a third keeps the previous settled value.
  always_ff @(posedge clk) begin
    sclS1 <= scl;
    sclS2 <= sclS1;
    sclS3 <= sclS2;
    sdaS1 <= sdaIn;
    sdaS2 <= sdaS1;
    sdaS3 <= sdaS2;
  end

  // Edges and bus conditions are derived from settled samples only.
  assign sclRise = sclS2 & ~sclS3;
  assign sclFall = ~sclS2 & sclS3;
  assign startSeen = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopSeen = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  assign fullByte = {shIn_q[6:0], sdaS2};

  // ----------------------------------------------------------------------------
  // Link sequencer.
  // ----------------------------------------------------------------------------

  // Shifts only between a start and a stop; pulses leave for one cycle.
  always_ff @(posedge clk) begin
    bus.wrValid <= 1'b0;
    bus.rdReq <= 1'b0;
    if (reset) begin
      state_q <= LINK_IDLE;
      bitCnt_q <= 3'h0;
      shIn_q <= 8'h00;
      shOut_q <= 8'h00;
      ackPend_q <= 1'b0;
      ackDrive_q <= 1'b0;
      isRead_q <= 1'b0;
      firstByte_q <= 1'b0;
      sdaOe <= 1'b0;
      bus.wrFirst <= 1'b0;
      bus.wrData <= 8'h00;
    end else if (startSeen) begin
      state_q <= LINK_ADDR;
      bitCnt_q <= 3'h0;
      ackPend_q <= 1'b0;
      ackDrive_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state_q <= LINK_IDLE;
      sdaOe <= 1'b0;
      ackPend_q <= 1'b0;
      ackDrive_q <= 1'b0;
    end else if (sclRise) begin
      case (state_q)
        LINK_ADDR, LINK_WRITE: begin
          shIn_q <= fullByte;
          bitCnt_q <= bitCnt_q + 3'h1;
          if (bitCnt_q == 3'h7) begin
            if (state_q == LINK_ADDR) begin
              if (fullByte[7:1] == DEV_ADDR) begin
                ackPend_q <= 1'b1;
                isRead_q <= fullByte[0];
                firstByte_q <= 1'b1;
                bus.rdReq <= fullByte[0];
              end else begin
                state_q <= LINK_IDLE;
              end
            end else begin
              bus.wrValid <= 1'b1;
              bus.wrFirst <= firstByte_q;
              bus.wrData <= fullByte;
              firstByte_q <= 1'b0;
              ackPend_q <= 1'b1;
            end
          end
        end
        LINK_READ: begin
          bitCnt_q <= bitCnt_q + 3'h1;
          if (bitCnt_q == 3'h7) begin
            state_q <= LINK_RACK;
          end
        end
        LINK_RACK: begin
          bitCnt_q <= 3'h0;
          if (!sdaS2) begin
            state_q <= LINK_READ;
            bus.rdReq <= 1'b1;
          end else begin
            state_q <= LINK_IDLE;
          end
        end
        default: begin
          bitCnt_q <= 3'h0;
        end
      endcase
    end else if (sclFall) begin
      if (ackPend_q) begin
        ackPend_q <= 1'b0;
        ackDrive_q <= 1'b1;
        sdaOe <= 1'b1;
      end else if (ackDrive_q) begin
        ackDrive_q <= 1'b0;
        bitCnt_q <= 3'h0;
        if (state_q == LINK_ADDR && isRead_q) begin
          state_q <= LINK_READ;
          shOut_q <= bus.rdData;
          sdaOe <= ~bus.rdData[7];
        end else begin
          state_q <= (state_q == LINK_ADDR) ? LINK_WRITE : state_q;
          sdaOe <= 1'b0;
        end
      end else if (state_q == LINK_READ) begin
        if (bitCnt_q == 3'h0) begin
          shOut_q <= bus.rdData;
          sdaOe <= ~bus.rdData[7];
        end else begin
          shOut_q <= {shOut_q[6:0], 1'b1};
          sdaOe <= ~shOut_q[6];
        end
      end else begin
        sdaOe <= 1'b0;
      end
    end
  end
endmodule

/* File: sgw_supervisor.sv */
/*
  Supervisor top: guard timer with power-cut output, calendar watchdog,
  register file behind the serial port, output gating and wake keys.
  Assumes a 10 MHz core clock, asynchronous pins for the handshake, wake,
  thermal comparators and serial bus, and key states from the scanner on the
  core clock.
*/
// What this block does
// - Guard timeout is 10 s after power-up, then programmable from 1 to 15 s.
// - Software may disable the guard timer; a wake out of power cut runs it again.
// - Host clears guard in time; otherwise power-cut output is asserted.
// - Guard starts on rising ready or wake pin; pressed wake keys, a level, restart it from power cut.
// - Writing the guard clear bit reloads the running guard count with the guard time.
// - Normal mode resumes the held count; boots start from configured value.
// - Watchdog register at 09h holds 5-bit multiplier and 3-bit resolution.
// - Resolution codes select 1/16 s, 1/4 s, 1 s, 4 s or 1 minute.
// - Watchdog timeout equals multiplier times the selected resolution.
// - Watchdog off at power-on and on 00h; any nonzero write enables it.
// - Every watchdog register write restarts the timeout period.
// - Watchdog expiry without a rewrite sets the watchdog flag.
// - Serial data shifts on clock rise only between start and stop.
// - Each received byte is latched whole, then decoded and executed.
// - Writes past the range are dropped; reads past it return all ones.
// - Power-up resets controls, blanks, enters low power, floats outputs.
// - Outputs off above 140 C, back on below 125 C, registers untouched.
// - Low power keeps configuration and restores outputs on leaving it.
// - Every segment has its own 8-step sink current setting.
// - Outputs not assigned to a digit or segment stay high impedance.
// - Any pressed key set may wake; each of 16 keys can be a wake key.
// - Power-cut rises on ready falling, standby command or guard at zero.
// - Guard timer is held inactive while in standby.
`include "sgw_regs.svh"

module sgw_supervisor #(
  parameter int TICK_CYCLES = `SGW_TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR = `SGW_DEV_ADDR // Arbitrary slave address.
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Host handshake and wake sources.
  input wire logic hostReady,
  input wire logic wakeIn,
  input wire logic [15:0] keyPressed,
  // Thermal comparators.
  input wire logic tempAbove140,
  input wire logic tempBelow125,
  // Serial bus pins.
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // System control.
  output logic power_cut_out,
  output logic wdog_enable_flag,
  output logic watchdogFlag,
  // Display outputs.
  output logic [12:0] outEnable,
  output logic [23:0] segCurrent
);
  import sgw_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  sgw_reg_if bus ();

  logic readyS1, readyS2, readyS3;
  logic wakeS1, wakeS2, wakeS3;
  logic hotS1, hotS2, coolS1, coolS2;
  logic [TW-1:0] tickCnt_q;
  logic tick16_q;
  logic [4:0] subSec_q;
  logic secTick_q;
  sgw_byte_t ctrl_q;
  logic [3:0] guardTime_q;
  logic [3:0] guardCnt_q;
  logic guardRun_q;
  logic powerCut_q;
  sgw_byte_t wdReg_q;
  logic [14:0] wdRemain_q;
  logic wdArmed_q;
  logic wdFlag_q;
  logic hot_q;
  logic [7:0] segUse_q;
  logic [4:0] digUse_q;
  logic [15:0] wakeMask_q;
  sgw_byte_t curr_q [4];
  sgw_byte_t ptr_q;
  logic [12:0] outEn_q;
  logic readyRise, readyFall, wakeRise, keyWake, wakeEvent;
  logic wrHit;

  // ----------------------------------------------------------------------------
  // Serial front end.
  // ----------------------------------------------------------------------------

  // The link drives only low; the pull-up makes the high level.
  sgw_serial_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .clk(ref_clk),
    .reset(reset),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .bus(bus.link)
  );
  assign sdaOut = 1'b0;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and events.
  // ----------------------------------------------------------------------------

  // Two flops per asynchronous pin; a third flop on ready and wake gives edge history.
  always_ff @(posedge ref_clk) begin
    readyS1 <= hostReady;
    readyS2 <= readyS1;
    readyS3 <= readyS2;
    wakeS1 <= wakeIn;
    wakeS2 <= wakeS1;
    wakeS3 <= wakeS2;
    hotS1 <= tempAbove140;
    hotS2 <= hotS1;
    coolS1 <= tempBelow125;
    coolS2 <= coolS1;
  end

  // Edge events for ready and wake, so a steady high there never retriggers the guard; key wake is a level.
  assign readyRise = readyS2 & ~readyS3;
  assign readyFall = ~readyS2 & readyS3;
  assign wakeRise = wakeS2 & ~wakeS3;
  assign keyWake = |(keyPressed & wakeMask_q);
  assign wakeEvent = readyRise | wakeRise | keyWake;
  assign wrHit = bus.wrValid & ~bus.wrFirst;

  // ----------------------------------------------------------------------------
  // Time base.
  // ----------------------------------------------------------------------------

  // Sixteenth-second tick from the core clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tickCnt_q <= '0;
      tick16_q <= 1'b0;
    end else if (tickCnt_q == TW'(TICK_CYCLES - 1)) begin
      tickCnt_q <= '0;
      tick16_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + TW'(1);
      tick16_q <= 1'b0;
    end
  end

  // One-second tick made of sixteen base ticks.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      subSec_q <= 5'h00;
      secTick_q <= 1'b0;
    end else begin
      secTick_q <= 1'b0;
      if (tick16_q) begin
        if (subSec_q == `SGW_TICKS_PER_SEC - 5'h01) begin
          subSec_q <= 5'h00;
          secTick_q <= 1'b1;
        end else begin
          subSec_q <= subSec_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------------

  // Control, guard period, output assignment, wake keys and currents.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= `SGW_CTRL_RESET;
      guardTime_q <= `SGW_GTIME_RESET;
      segUse_q <= 8'h00;
      digUse_q <= 5'h00;
      wakeMask_q <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        curr_q[i] <= 8'h00;
      end
    end else if (wrHit) begin
      case (ptr_q)
        `SGW_ADDR_CTRL: ctrl_q <= bus.wrData & 8'h19;
        `SGW_ADDR_GTIME: begin
          guardTime_q <= (bus.wrData[3:0] == 4'h0) ? `SGW_GTIME_MIN : bus.wrData[3:0];
        end
        `SGW_ADDR_SEGUSE: segUse_q <= bus.wrData;
        `SGW_ADDR_DIGUSE: digUse_q <= bus.wrData[4:0];
        `SGW_ADDR_WAKELO: wakeMask_q[7:0] <= bus.wrData;
        `SGW_ADDR_WAKEHI: wakeMask_q[15:8] <= bus.wrData;
        8'h0A, 8'h0B, 8'h0C, 8'h0D: begin
          curr_q[2'(ptr_q - `SGW_ADDR_CURR0)] <= bus.wrData & 8'h77;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Guard timer and power cut.
  // ----------------------------------------------------------------------------

  // Cold boot runs the guard from its default; later events follow priority.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      guardRun_q <= 1'b1;
      guardCnt_q <= `SGW_GTIME_RESET;
      powerCut_q <= 1'b0;
    end else if (powerCut_q) begin
      guardRun_q <= 1'b0;
      if (wakeEvent) begin
        powerCut_q <= 1'b0;
        guardRun_q <= 1'b1;
        guardCnt_q <= guardTime_q;
      end
    end else if (readyFall) begin
      powerCut_q <= 1'b1;
      guardRun_q <= 1'b0;
    end else if (wrHit && ptr_q == `SGW_ADDR_CTRL && bus.wrData[`SGW_CTRL_POWER_CUT_OUT]) begin
      powerCut_q <= 1'b1;
      guardRun_q <= 1'b0;
    end else if (readyRise || wakeRise) begin
      guardRun_q <= ctrl_q[`SGW_CTRL_GEN];
      guardCnt_q <= guardTime_q;
    end else if (wrHit && ptr_q == `SGW_ADDR_CTRL) begin
      guardRun_q <= bus.wrData[`SGW_CTRL_GEN];
      if (bus.wrData[`SGW_CTRL_GCLR]) begin
        guardCnt_q <= guardTime_q;
      end
    end else if (secTick_q && guardRun_q) begin
      if (guardCnt_q <= 4'h1) begin
        guardCnt_q <= 4'h0;
        guardRun_q <= 1'b0;
        powerCut_q <= 1'b1;
      end else begin
        guardCnt_q <= guardCnt_q - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Calendar watchdog.
  // ----------------------------------------------------------------------------

  // Length of one resolution step in sixteenth-second ticks.
  function automatic logic [9:0] resTicks(input logic [2:0] res);
    case (res)
      `SGW_RES_16TH: resTicks = `SGW_TICKS_16TH;
      `SGW_RES_QUART: resTicks = `SGW_TICKS_QUART;
      `SGW_RES_SEC: resTicks = `SGW_TICKS_SEC;
      `SGW_RES_4SEC: resTicks = `SGW_TICKS_4SEC;
      `SGW_RES_MIN: resTicks = `SGW_TICKS_MIN;
      default: resTicks = 10'h000;
    endcase
  endfunction

  // Each write reloads the period; expiry sets the flag, set wins over clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdReg_q <= `SGW_WDOG_RESET;
      wdRemain_q <= 15'h0000;
      wdArmed_q <= 1'b0;
      wdFlag_q <= 1'b0;
    end else begin
      if (wrHit && ptr_q == `SGW_ADDR_STATUS && bus.wrData[`SGW_STAT_WDF]) begin
        wdFlag_q <= 1'b0;
      end
      if (wrHit && ptr_q == `SGW_ADDR_WDOG) begin
        wdReg_q <= bus.wrData;
        wdArmed_q <= (bus.wrData != 8'h00);
        wdRemain_q <= 15'(bus.wrData[`SGW_WD_MULT_HI:`SGW_WD_MULT_LO])
                      * 15'(resTicks(bus.wrData[`SGW_WD_RES_HI:`SGW_WD_RES_LO]));
      end else if (tick16_q && wdArmed_q) begin
        if (wdRemain_q <= 15'h0001) begin
          wdRemain_q <= 15'h0000;
          wdArmed_q <= 1'b0;
          wdFlag_q <= 1'b1;
        end else begin
          wdRemain_q <= wdRemain_q - 15'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Thermal cut-off and output enables.
  // ----------------------------------------------------------------------------

  // Hysteresis between the two comparators; registers are not touched.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hot_q <= 1'b0;
    end else if (hotS2) begin
      hot_q <= 1'b1;
    end else if (coolS2) begin
      hot_q <= 1'b0;
    end
  end

  // Only assigned pins drive, and only when lit, awake and cool.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outEn_q <= 13'h0000;
    end else if (ctrl_q[`SGW_CTRL_LP] || !ctrl_q[`SGW_CTRL_DISP] || hot_q) begin
      outEn_q <= 13'h0000;
    end else begin
      outEn_q <= {digUse_q, segUse_q};
    end
  end

  // ----------------------------------------------------------------------------
  // Register pointer and read data.
  // ----------------------------------------------------------------------------

  // Pointer loads from the first byte and advances, sticking at the top.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_q <= 8'h00;
    end else if (bus.wrValid && bus.wrFirst) begin
      ptr_q <= bus.wrData;
    end else if ((wrHit || bus.rdReq) && ptr_q != 8'hFF) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Read byte ready well before the next falling bus clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus.rdData <= `SGW_READ_FILL;
    end else if (bus.rdReq) begin
      case (ptr_q)
        `SGW_ADDR_CTRL: bus.rdData <= ctrl_q;
        `SGW_ADDR_GTIME: bus.rdData <= {4'h0, guardTime_q};
        `SGW_ADDR_STATUS: bus.rdData <= {4'h0, guardRun_q, hot_q, wdFlag_q, powerCut_q};
        `SGW_ADDR_GCOUNT: bus.rdData <= {4'h0, guardCnt_q};
        `SGW_ADDR_SEGUSE: bus.rdData <= segUse_q;
        `SGW_ADDR_DIGUSE: bus.rdData <= {3'h0, digUse_q};
        `SGW_ADDR_WAKELO: bus.rdData <= wakeMask_q[7:0];
        `SGW_ADDR_WAKEHI: bus.rdData <= wakeMask_q[15:8];
        8'h08: bus.rdData <= 8'h00;
        `SGW_ADDR_WDOG: bus.rdData <= wdReg_q;
        8'h0A, 8'h0B, 8'h0C, 8'h0D: bus.rdData <= curr_q[2'(ptr_q - `SGW_ADDR_CURR0)];
        default: bus.rdData <= `SGW_READ_FILL;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------

  // All outputs come from flops, except sdaOut, which is tied low.
  assign power_cut_out = powerCut_q;
  assign wdog_enable_flag = wdArmed_q;
  assign watchdogFlag = wdFlag_q;
  assign outEnable = outEn_q;
  assign segCurrent = {curr_q[3][6:4], curr_q[3][2:0], curr_q[2][6:4], curr_q[2][2:0],
                       curr_q[1][6:4], curr_q[1][2:0], curr_q[0][6:4], curr_q[0][2:0]};
endmodule

/* File: sgw_sup_asserts.sv */
/*
  Checker on the supervisor top ports.
  Assumes it is bound to every instance of the top module.
*/
module sgw_sup_asserts (
  // Clock, reset and pins in.
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hostReady,
  input wire logic wakeIn,
  input wire logic [15:0] keyPressed,
  input wire logic tempAbove140,
  input wire logic tempBelow125,
  input wire logic scl,
  // Outputs watched.
  input wire logic sdaOe,
  input wire logic power_cut_out,
  input wire logic wdog_enable_flag,
  input wire logic watchdogFlag,
  input wire logic [12:0] outEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Reset is checked while it is held, so it has no disable condition.
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !power_cut_out && !sdaOe && !watchdogFlag
    && !wdog_enable_flag && outEnable == 13'h0000) else $error("outputs not quiet in reset");
  a_hot_dark: assert property (tempAbove140 [*6] |=> outEnable == 13'h0000) else $error("on while hot");
  a_cool_wait: assert property (!tempBelow125 && outEnable == 13'h0000 |=> outEnable == 13'h0000)
    else $error("on before cooling");
  a_wd_armed: assert property ($rose(watchdogFlag) |-> $past(wdog_enable_flag)) else $error("flag unarmed");
  a_cut_ready: assert property ($fell(hostReady) && !power_cut_out |-> ##[1:6] power_cut_out)
    else $error("no cut after ready fall");
  a_wake_run: assert property ($rose(wakeIn) && power_cut_out |-> ##[1:6] !power_cut_out)
    else $error("wake rise kept cut");
  a_ack_low: assert property ($rose(sdaOe) |-> !$past(scl)) else $error("data moved with clock high");
  a_cut_hold: assert property ($fell(power_cut_out) |-> $past(hostReady) || $past(wakeIn)
    || $past(keyPressed) != 16'h0000) else $error("cut released without wake");
endmodule

bind sgw_supervisor sgw_sup_asserts u_chk (.*);

/* File: sgw_host.sv */
/*
  Host model: serial bus master that drives the clock and pulls data low.
  Assumes the bench resolves the data line with a pull-up.
*/
module sgw_host (
  // Clock and data line in.
  input wire logic ref_clk,
  input wire logic sda,
  // Bus drive out.
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus released and the clock parked high outside frames.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // One bit of 800 ns: data moves only while the clock is low.
  task automatic bit1(input logic b, output logic r);
    scl <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sdaLow <= !b;
    repeat (2) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    r = sda;
  endtask
  // Start when a is 0 and b is 1, stop when a is 1 and b is 0.
  task automatic cond(input logic a, input logic b);
    scl <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sdaLow <= a;
    repeat (2) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sdaLow <= b;
    repeat (4) @(posedge ref_clk);
  endtask
  // Whole byte, MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(rel, a);
    ack = !a;
  endtask
endmodule

/* File: tb_top.sv */
/*
  Bench: guard, watchdog, thermal and register checks through the host model.
  Assumes TICK_CYCLES of 10, so one second is 160 clocks.
*/
`include "sgw_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sgw_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, hostReady = 1'b0, wakeIn = 1'b0, tempAbove140 = 1'b0, tempBelow125 = 1'b1;
  logic [15:0] keyPressed = 16'h0000;
  logic scl, sdaIn, sdaOe, hostLow, power_cut_out, wdog_enable_flag, watchdogFlag, k;
  logic [12:0] outEnable;
  logic [23:0] segCurrent;
  int n_mismatch = 0, check_count = 0, seed = 95330, cyc, wcnt, t0, m;
  int tk[5] = '{1, 4, 16, 64, 960};
  sgw_byte_t q;
  // Clock, pulled-up data line and cycle counters.
  always #50 ref_clk = ~ref_clk;
  assign sdaIn = !(sdaOe | hostLow);
  always @(posedge ref_clk) cyc <= reset ? 0 : cyc + 1;
  always @(posedge ref_clk) wcnt <= wdog_enable_flag ? wcnt + 1 : 0;
  sgw_supervisor #(.TICK_CYCLES(10)) u_dut (.*, .sdaOut());
  sgw_host u_host (.ref_clk, .sda(sdaIn), .scl, .sdaLow(hostLow));
  // Compare one result and count it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A used-up wait counts as a mismatch and ends the run.
  task automatic tmo(input int c, input int lim);
    if (c >= lim) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic wcut(input logic v, input int lim);
    int c;
    for (c = 0; c < lim && power_cut_out !== v; c++) @(negedge ref_clk);
    tmo(c, lim);
  endtask
  task automatic wr(input sgw_byte_t p, input sgw_byte_t d);
    u_host.cond(1'b0, 1'b1);
    u_host.xfer({`SGW_DEV_ADDR, 1'b0}, 1'b1, q, k);
    u_host.xfer(p, 1'b1, q, k);
    u_host.xfer(d, 1'b1, q, k);
    u_host.cond(1'b1, 1'b0);
  endtask
  task automatic rd(input sgw_byte_t p);
    u_host.cond(1'b0, 1'b1);
    u_host.xfer({`SGW_DEV_ADDR, 1'b0}, 1'b1, q, k);
    u_host.xfer(p, 1'b1, q, k);
    u_host.cond(1'b0, 1'b1);
    u_host.xfer({`SGW_DEV_ADDR, 1'b1}, 1'b1, q, k);
    u_host.xfer(8'hFF, 1'b1, q, k);
    u_host.cond(1'b1, 1'b0);
  endtask
  // Main sequence: guard, watchdog, then outputs and registers.
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk({power_cut_out, watchdogFlag, wdog_enable_flag, outEnable}, 16'h0000);
    repeat (4) @(posedge ref_clk);
    wr(8'h01, 8'h02);
    wcut(1'b1, 2000);
    chk(cyc > 1440 && cyc <= 1610, 1'b1);
    @(posedge ref_clk) wakeIn <= 1'b1;
    t0 = cyc;
    wcut(1'b0, 10);
    wcut(1'b1, 400);
    chk(cyc - t0 > 300 && cyc - t0 <= 330, 1'b1);
    @(posedge ref_clk) hostReady <= 1'b1;
    wakeIn <= 1'b0;
    wcut(1'b0, 10);
    repeat (20) @(posedge ref_clk);
    hostReady <= 1'b0;
    wcut(1'b1, 7);
    chk(power_cut_out, 1'b1);
    @(posedge ref_clk) wakeIn <= 1'b1;
    wcut(1'b0, 10);
    repeat (20) @(posedge ref_clk);
    hostReady <= 1'b1;
    repeat (700) @(negedge ref_clk);
    chk(power_cut_out, 1'b0);
    $display("guard test done");
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 3 + ($random(seed) & 15) : 1;
      @(posedge ref_clk) wr(8'h09, 8'h00);
      chk(wdog_enable_flag, 1'b0);
      wr(8'h02, 8'h02);
      wr(8'h09, {m[4:0], i[2:0]});
      chk(wdog_enable_flag, 1'b1);
      for (t0 = 0; t0 < 12000 && watchdogFlag !== 1'b1; t0++) @(negedge ref_clk);
      tmo(t0, 12000);
      chk(wcnt > (m * tk[i] - 1) * 10 && wcnt <= m * tk[i] * 10 + 3, 1'b1);
    end
    @(posedge ref_clk) rd(8'h09);
    chk(q, 8'h0C);
    $display("watchdog test done");
    keyPressed <= 16'($random(seed));
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'h1F);
    wr(8'h00, 8'h10);
    wr(8'h0A, 8'h53);
    chk(outEnable, 13'h1FFF);
    chk(segCurrent[5:0], 6'h2B);
    tempAbove140 <= 1'b1;
    tempBelow125 <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(outEnable, 13'h0000);
    @(posedge ref_clk) tempAbove140 <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(outEnable, 13'h0000);
    @(posedge ref_clk) tempBelow125 <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(outEnable, 13'h1FFF);
    @(posedge ref_clk) rd(8'h0A);
    chk(q, 8'h53);
    rd(8'h0E);
    chk(q, 8'hFF);
    $display("output test done");
    stop_test();
  end
endmodule
